// [crkr_pkg.sv]
// Package with opcodes, status codes, sizes and states of the command interpreter
package crkr_pkg;

  localparam logic [9:0]  OPC_DECLINE   = 10'h00A;
  localparam logic [9:0]  OPC_KEY_SUPPLY = 10'h00B;
  localparam logic [9:0]  OPC_KEY_ABSENT = 10'h00C;

  localparam int          ADDR_W        = 48;
  localparam int          KEY_W         = 128;

  localparam logic [7:0]  ST_SUCCESS    = 8'h00;
  localparam logic [7:0]  ST_UNKNOWN_CONN = 8'h02;
  localparam logic [7:0]  ST_CMD_DISALLOWED = 8'h0C;
  localparam logic [7:0]  ST_BAD_PARAM  = 8'h12;
  localparam logic [7:0]  ST_UNKNOWN_CMD = 8'h01;
  localparam logic [7:0]  REASON_MIN    = 8'h0D;
  localparam logic [7:0]  REASON_MAX    = 8'h0F;

  localparam logic [7:0]  EVT_NONE      = 8'h00;
  localparam logic [7:0]  EVT_CONN_COMPLETE = 8'h03;
  localparam logic [7:0]  EVT_CMD_COMPLETE  = 8'h0E;
  localparam logic [7:0]  EVT_CMD_STATUS    = 8'h0F;
  localparam logic [7:0]  EVT_KEY_REQUEST   = 8'h17;

  typedef enum logic [2:0] {
    CRKR_IDLE,
    CRKR_DEC_STATUS,
    CRKR_DEC_LOCAL,
    CRKR_DEC_PEER,
    CRKR_KEY_EVT,
    CRKR_REPLY_DONE
  } crkr_state_t;

endpackage

// [crkr_match_if.sv]
// Interface carrying one address comparison between the top and the matcher
`timescale 1ns/10ps
interface crkr_match_if;
  logic [crkr_pkg::ADDR_W-1:0] stored_addr;
  logic                        stored_valid;
  logic [crkr_pkg::ADDR_W-1:0] cmd_addr;
  logic                        hit;

  modport owner (output stored_addr, output stored_valid, output cmd_addr, input hit);
  modport matcher (input stored_addr, input stored_valid, input cmd_addr, output hit);
endinterface

// [crkr_addr_match.sv]
// Compares a command's peer address with an outstanding request
`timescale 1ns/10ps
module crkr_addr_match
(
  crkr_match_if.matcher m   // Comparison operands and result
);

  // Per-byte compare, all must agree
  logic [5:0] byte_eq;

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_byte
      assign byte_eq[g] = (m.stored_addr[g*8 +: 8] == m.cmd_addr[g*8 +: 8]);
    end
  endgenerate

  assign m.hit = m.stored_valid & (&byte_eq);

endmodule

// [crkr_top.sv]
// Decline-connection and key-reply command interpreter
`timescale 1ns/10ps
module crkr_top
(
  input  wire logic                         clk_sys_i,        // System clock, 250 MHz
  input  wire logic                         rst_i,            // Async reset, active high
  // Host command port
  input  wire logic                         cmd_valid_i,      // Command present
  output logic                              cmd_ready_o,      // Command taken
  input  wire logic [9:0]                   cmd_opcode_command_field_i, // Opcode field
  input  wire logic [crkr_pkg::ADDR_W-1:0]  cmd_peer_device_address_i,  // Peer address
  input  wire logic [7:0]                   cmd_reason_i,     // Decline cause
  input  wire logic [crkr_pkg::KEY_W-1:0]   cmd_key_i,        // Supplied key
  // Link side: connection requests and key needs
  input  wire logic                         conn_req_i,       // Incoming connection request
  input  wire logic                         key_need_i,       // Key needed for a peer
  input  wire logic [crkr_pkg::ADDR_W-1:0]  link_peer_device_address_i, // Peer of request
  // Host event port
  output logic                              evt_valid_o,      // Event present
  input  wire logic                         evt_ready_i,      // Event accepted
  output logic [7:0]                        evt_code_o,       // Event code
  output logic [7:0]                        evt_status_o,     // Status byte
  output logic [9:0]                        evt_opcode_command_field_o, // Opcode answered
  output logic [crkr_pkg::ADDR_W-1:0]       evt_peer_device_address_o,  // Address field
  output logic                              evt_to_peer_o,    // Event bound for peer host
  // Link manager outputs
  output logic                              key_valid_o,      // Key delivered, one cycle
  output logic                              key_absent_o,     // No key, one cycle
  output logic [crkr_pkg::KEY_W-1:0]        key_o,            // Delivered key
  output logic                              decline_o         // Decline issued, one cycle
);

  // ************************************************
  // Decoding
  // ************************************************
  function automatic logic is_known(input logic [9:0] op);
    is_known = (op == crkr_pkg::OPC_DECLINE) || (op == crkr_pkg::OPC_KEY_SUPPLY) ||
               (op == crkr_pkg::OPC_KEY_ABSENT);
  endfunction

  crkr_pkg::crkr_state_t             state_ff, nxt_state;
  logic [crkr_pkg::ADDR_W-1:0]       conn_addr_ff, nxt_conn_addr;
  logic                              conn_pend_ff, nxt_conn_pend;
  logic [crkr_pkg::ADDR_W-1:0]       key_addr_ff, nxt_key_addr;
  logic                              key_pend_ff, nxt_key_pend;
  logic [9:0]                        op_ff, nxt_op;
  logic [7:0]                        status_ff, nxt_status;
  logic [7:0]                        reason_ff, nxt_reason;
  logic [crkr_pkg::ADDR_W-1:0]       addr_ff, nxt_addr;
  logic [crkr_pkg::KEY_W-1:0]        key_ff, nxt_key;
  logic                              kval_ff, nxt_kval;
  logic                              kabs_ff, nxt_kabs;
  logic                              dec_ff, nxt_dec;
  logic [7:0]                        evt_code_ff, nxt_evt_code;
  logic [7:0]                        evt_stat_ff, nxt_evt_stat;
  logic                              to_peer_ff, nxt_to_peer;

  crkr_match_if conn_m ();
  crkr_match_if key_m ();

  assign conn_m.stored_addr  = conn_addr_ff;
  assign conn_m.stored_valid = conn_pend_ff;
  assign conn_m.cmd_addr     = cmd_peer_device_address_i;
  assign key_m.stored_addr   = key_addr_ff;
  assign key_m.stored_valid  = key_pend_ff;
  assign key_m.cmd_addr      = cmd_peer_device_address_i;

  crkr_addr_match u_conn_match
  (
    .m (conn_m)
  );

  crkr_addr_match u_key_match
  (
    .m (key_m)
  );

  // ************************************************
  // Next state
  // ************************************************
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_conn_addr = conn_addr_ff;
    nxt_conn_pend = conn_pend_ff;
    nxt_key_addr  = key_addr_ff;
    nxt_key_pend  = key_pend_ff;
    nxt_op        = op_ff;
    nxt_status    = status_ff;
    nxt_reason    = reason_ff;
    nxt_addr      = addr_ff;
    nxt_key       = key_ff;
    nxt_kval      = 1'b0;
    nxt_kabs      = 1'b0;
    nxt_dec       = 1'b0;
    cmd_ready_o   = 1'b0;

    // Outstanding connection request, kept until declined
    if (conn_req_i && !conn_pend_ff)
    begin
      nxt_conn_addr = link_peer_device_address_i;
      nxt_conn_pend = 1'b1;
    end

    case (state_ff)
      crkr_pkg::CRKR_IDLE:
      begin
        if (key_need_i && !key_pend_ff)
        begin
          nxt_key_addr = link_peer_device_address_i;
          nxt_key_pend = 1'b1;
          nxt_addr     = link_peer_device_address_i;
          nxt_state    = crkr_pkg::CRKR_KEY_EVT;
        end
        else if (cmd_valid_i)
        begin
          cmd_ready_o = 1'b1;
          nxt_op      = cmd_opcode_command_field_i;
          nxt_addr    = cmd_peer_device_address_i;
          nxt_reason  = cmd_reason_i;
          nxt_status  = crkr_pkg::ST_SUCCESS;
          if (!is_known(cmd_opcode_command_field_i))
          begin
            nxt_status = crkr_pkg::ST_UNKNOWN_CMD;
            nxt_state  = crkr_pkg::CRKR_DEC_STATUS;
          end
          else if (cmd_opcode_command_field_i == crkr_pkg::OPC_DECLINE)
          begin
            if (!conn_m.hit)
              nxt_status = crkr_pkg::ST_UNKNOWN_CONN;
            else if (cmd_reason_i < crkr_pkg::REASON_MIN ||
                     cmd_reason_i > crkr_pkg::REASON_MAX)
              nxt_status = crkr_pkg::ST_BAD_PARAM;
            nxt_state = crkr_pkg::CRKR_DEC_STATUS;
          end
          else
          begin
            if (!key_m.hit)
              nxt_status = crkr_pkg::ST_UNKNOWN_CONN;
            else
            begin
              nxt_key_pend = 1'b0;
              if (cmd_opcode_command_field_i == crkr_pkg::OPC_KEY_SUPPLY)
              begin
                nxt_key  = cmd_key_i;
                nxt_kval = 1'b1;
              end
              else
                nxt_kabs = 1'b1;
            end
            nxt_state = crkr_pkg::CRKR_REPLY_DONE;
          end
        end
      end
      crkr_pkg::CRKR_DEC_STATUS:
      begin
        if (evt_ready_i)
        begin
          if (op_ff == crkr_pkg::OPC_DECLINE && status_ff == crkr_pkg::ST_SUCCESS)
          begin
            nxt_dec       = 1'b1;
            nxt_conn_pend = 1'b0;
            nxt_state     = crkr_pkg::CRKR_DEC_LOCAL;
          end
          else
            nxt_state = crkr_pkg::CRKR_IDLE;
        end
      end
      crkr_pkg::CRKR_DEC_LOCAL:
        if (evt_ready_i)
          nxt_state = crkr_pkg::CRKR_DEC_PEER;
      crkr_pkg::CRKR_DEC_PEER, crkr_pkg::CRKR_KEY_EVT, crkr_pkg::CRKR_REPLY_DONE:
        if (evt_ready_i)
          nxt_state = crkr_pkg::CRKR_IDLE;
      default:
        nxt_state = crkr_pkg::CRKR_IDLE;
    endcase
  end

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff     <= crkr_pkg::CRKR_IDLE;
      conn_addr_ff <= '0;
      conn_pend_ff <= 1'b0;
      key_addr_ff  <= '0;
      key_pend_ff  <= 1'b0;
      op_ff        <= '0;
      status_ff    <= crkr_pkg::ST_SUCCESS;
      reason_ff    <= '0;
      addr_ff      <= '0;
      key_ff       <= '0;
      kval_ff      <= 1'b0;
      kabs_ff      <= 1'b0;
      dec_ff       <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      conn_addr_ff <= nxt_conn_addr;
      conn_pend_ff <= nxt_conn_pend;
      key_addr_ff  <= nxt_key_addr;
      key_pend_ff  <= nxt_key_pend;
      op_ff        <= nxt_op;
      status_ff    <= nxt_status;
      reason_ff    <= nxt_reason;
      addr_ff      <= nxt_addr;
      key_ff       <= nxt_key;
      kval_ff      <= nxt_kval;
      kabs_ff      <= nxt_kabs;
      dec_ff       <= nxt_dec;
    end
  end

  // ************************************************
  // Event output
  // ************************************************
  // Fields follow the state being entered, so they leave flip-flops
  always_comb
  begin
    nxt_evt_code = crkr_pkg::EVT_NONE;
    nxt_evt_stat = nxt_status;
    nxt_to_peer  = 1'b0;
    case (nxt_state)
      crkr_pkg::CRKR_DEC_STATUS:  nxt_evt_code = crkr_pkg::EVT_CMD_STATUS;
      crkr_pkg::CRKR_DEC_LOCAL:   nxt_evt_code = crkr_pkg::EVT_CONN_COMPLETE;
      crkr_pkg::CRKR_DEC_PEER:
      begin
        nxt_evt_code = crkr_pkg::EVT_CONN_COMPLETE;
        nxt_evt_stat = nxt_reason;
        nxt_to_peer  = 1'b1;
      end
      crkr_pkg::CRKR_KEY_EVT:     nxt_evt_code = crkr_pkg::EVT_KEY_REQUEST;
      crkr_pkg::CRKR_REPLY_DONE:  nxt_evt_code = crkr_pkg::EVT_CMD_COMPLETE;
      default:                    nxt_evt_code = crkr_pkg::EVT_NONE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      evt_code_ff <= crkr_pkg::EVT_NONE;
      evt_stat_ff <= crkr_pkg::ST_SUCCESS;
      to_peer_ff  <= 1'b0;
    end
    else
    begin
      evt_code_ff <= nxt_evt_code;
      evt_stat_ff <= nxt_evt_stat;
      to_peer_ff  <= nxt_to_peer;
    end
  end

  assign evt_valid_o   = (evt_code_ff != crkr_pkg::EVT_NONE);
  assign evt_code_o    = evt_code_ff;
  assign evt_status_o  = evt_stat_ff;
  assign evt_to_peer_o = to_peer_ff;
  assign evt_opcode_command_field_o = op_ff;
  assign evt_peer_device_address_o  = addr_ff;
  assign key_valid_o  = kval_ff;
  assign key_absent_o = kabs_ff;
  assign key_o        = key_ff;
  assign decline_o    = dec_ff;

endmodule

// [crkr_sva.sv]
// Checker for the command and event ports of the interpreter
`timescale 1ns/10ps
module crkr_sva
(
  input wire logic        clk_sys_i,                  // Clock
  input wire logic        rst_i,                      // Reset
  input wire logic        cmd_valid_i,                // Command present
  input wire logic        cmd_ready_o,                // Command taken
  input wire logic [9:0]  cmd_opcode_command_field_i, // Opcode
  input wire logic [47:0] cmd_peer_device_address_i,  // Address
  input wire logic        evt_valid_o,                // Event present
  input wire logic [7:0]  evt_code_o,                 // Event code
  input wire logic [7:0]  evt_status_o,               // Status
  input wire logic [9:0]  evt_opcode_command_field_o, // Opcode answered
  input wire logic [47:0] evt_peer_device_address_o,  // Address field
  input wire logic        evt_to_peer_o,              // Peer event
  input wire logic        key_valid_o,                // Key pulse
  input wire logic        key_absent_o,               // No-key pulse
  input wire logic        decline_o                   // Decline pulse
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic tk, kop, cc;
  assign tk  = cmd_valid_i && cmd_ready_o;
  assign kop = (cmd_opcode_command_field_i == crkr_pkg::OPC_KEY_SUPPLY) ||
               (cmd_opcode_command_field_i == crkr_pkg::OPC_KEY_ABSENT);
  assign cc  = evt_valid_o && evt_code_o == crkr_pkg::EVT_CMD_COMPLETE;
  property p_dec_status;
    tk && cmd_opcode_command_field_i == crkr_pkg::OPC_DECLINE
      |=> evt_valid_o && evt_code_o == crkr_pkg::EVT_CMD_STATUS;
  endproperty
  a_dec_status: assert property (p_dec_status)
    else $error("decline lacks status event");
  property p_dec_no_cc;
    cc |-> evt_opcode_command_field_o != crkr_pkg::OPC_DECLINE;
  endproperty
  a_dec_no_cc: assert property (p_dec_no_cc)
    else $error("decline gave complete event");
  property p_key_cc;
    tk && kop |=> cc && evt_opcode_command_field_o == $past(cmd_opcode_command_field_i);
  endproperty
  a_key_cc: assert property (p_key_cc)
    else $error("key reply lacks complete event");
  property p_key_addr;
    tk && kop |=> evt_peer_device_address_o == $past(cmd_peer_device_address_i);
  endproperty
  a_key_addr: assert property (p_key_addr)
    else $error("key reply address wrong");
  property p_peer_reason;
    evt_valid_o && evt_to_peer_o
      |-> evt_code_o == crkr_pkg::EVT_CONN_COMPLETE &&
          evt_status_o >= crkr_pkg::REASON_MIN && evt_status_o <= crkr_pkg::REASON_MAX;
  endproperty
  a_peer_reason: assert property (p_peer_reason)
    else $error("peer event status wrong");
  property p_supply_ok;
    key_valid_o
      |-> cc && evt_opcode_command_field_o == crkr_pkg::OPC_KEY_SUPPLY &&
          evt_status_o == crkr_pkg::ST_SUCCESS;
  endproperty
  a_supply_ok: assert property (p_supply_ok)
    else $error("key given without success");
  property p_absent_ok;
    key_absent_o
      |-> cc && evt_opcode_command_field_o == crkr_pkg::OPC_KEY_ABSENT &&
          evt_status_o == crkr_pkg::ST_SUCCESS;
  endproperty
  a_absent_ok: assert property (p_absent_ok)
    else $error("no-key without success");
  property p_dec_pulse;
    decline_o
      |-> evt_valid_o && evt_code_o == crkr_pkg::EVT_CONN_COMPLETE && !evt_to_peer_o &&
          evt_status_o == crkr_pkg::ST_SUCCESS;
  endproperty
  a_dec_pulse: assert property (p_dec_pulse)
    else $error("decline without local complete");
endmodule
bind crkr_top crkr_sva u_sva (.*);

// [crkr_host_model.sv]
// Host side event acceptor, prompt or stalling
`timescale 1ns/10ps
module crkr_host_model
(
  input  wire logic clk_sys_i,   // Clock
  input  wire logic rst_i,       // Reset
  input  wire logic slow_i,      // Accept every other cycle
  output logic      evt_ready_o  // Event accepted
);
  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      evt_ready_o <= 1'b0;
    else
      evt_ready_o <= #1 slow_i ? ~evt_ready_o : 1'b1;
endmodule

// [test_conn_reject_key_reply_cmds.sv]
// Self-checking bench for the decline and key-reply interpreter
`timescale 1ns/10ps
module test_conn_reject_key_reply_cmds;
  localparam logic [7:0] CS = crkr_pkg::EVT_CMD_STATUS;
  localparam logic [7:0] CC = crkr_pkg::EVT_CMD_COMPLETE;
  localparam logic [7:0] CN = crkr_pkg::EVT_CONN_COMPLETE;
  localparam logic [7:0] KR = crkr_pkg::EVT_KEY_REQUEST;
  logic         clk = 0, rst = 1, cv = 0, cr, crq = 0, kn = 0, ev, er, tp, kv, ka, dc, slow = 0;
  logic [9:0]   op = 0, eop;
  logic [7:0]   rs = 0, ec, es;
  logic [47:0]  ad = 0, la = 0, ea;
  logic [127:0] ky = 0, ko;
  int           mismatches = 0, cmp_count = 0;
  crkr_top u_dut (.clk_sys_i(clk), .rst_i(rst), .cmd_valid_i(cv), .cmd_ready_o(cr),
    .cmd_opcode_command_field_i(op), .cmd_peer_device_address_i(ad), .cmd_reason_i(rs),
    .cmd_key_i(ky), .conn_req_i(crq), .key_need_i(kn), .link_peer_device_address_i(la),
    .evt_valid_o(ev), .evt_ready_i(er), .evt_code_o(ec), .evt_status_o(es),
    .evt_opcode_command_field_o(eop), .evt_peer_device_address_o(ea), .evt_to_peer_o(tp),
    .key_valid_o(kv), .key_absent_o(ka), .key_o(ko), .decline_o(dc));
  crkr_host_model u_host (.clk_sys_i(clk), .rst_i(rst), .slow_i(slow), .evt_ready_o(er));
  task automatic chk(input string nm, input logic [127:0] e, g);
    cmp_count++;
    if (e !== g)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send(input logic [9:0] o, input logic [47:0] a, input logic [7:0] r,
                      input logic [127:0] k);
    int   n;
    logic tk;
    n  = 0;
    tk = 1'b0;
    cv = 1;
    op = o;
    ad = a;
    rs = r;
    ky = k;
    // Ready sampled once settled, before the edge that takes the command
    do
    begin
      #1 tk = (cr === 1'b1);
      @(posedge clk);
      n++;
    end
    while (!tk && n < 50);
    #1 cv = 0;
    chk("cmd_taken", 128'(1'b1), 128'(tk));
  endtask
  task automatic get_evt(input logic [7:0] c, s, input logic [47:0] a, input logic p,
                         input logic [2:0] pl);
    int n;
    n = 0;
    while (ev !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk("code", 128'(c), 128'(ec));
    if (c != CS) chk("address", 128'(a), 128'(ea));
    if (c != KR) chk("status", 128'(s), 128'(es));
    chk("to_peer", 128'(p), 128'(tp));
    chk("pulses", 128'(pl), 128'({dc, kv, ka}));
    do @(posedge clk); while (er !== 1'b1);
    #1;
  endtask
  task automatic creq(input logic [47:0] a);
    la  = a;
    crq = 1;
    @(posedge clk);
    #1 crq = 0;
  endtask
  task automatic kreq(input logic [47:0] a);
    la = a;
    kn = 1;
    @(posedge clk);
    #1 kn = 0;
    get_evt(KR, 8'h00, a, 1'b0, 3'b000);
  endtask
  task automatic dec_ok(input logic [47:0] a, input logic [7:0] r);
    send(crkr_pkg::OPC_DECLINE, a, r, 0);
    get_evt(CS, 8'h00, a, 1'b0, 3'b000);
    get_evt(CN, 8'h00, a, 1'b0, 3'b100);
    get_evt(CN, r, a, 1'b1, 3'b000);
  endtask
  // ************
  // Scenarios
  // ************
  task automatic t_decline;
    for (int r = 13; r <= 15; r++)
    begin
      creq(48'h5a5a_0000_0000 + 48'(r));
      dec_ok(48'h5a5a_0000_0000 + 48'(r), 8'(r));
    end
  endtask
  task automatic t_decline_refused;
    creq(48'h0123_4567_89ab);
    send(crkr_pkg::OPC_DECLINE, 48'h0123_4567_89aa, 8'h0e, 0);
    get_evt(CS, 8'h02, 0, 1'b0, 3'b000);
    send(crkr_pkg::OPC_DECLINE, 48'h0123_4567_89ab, 8'h10, 0);
    get_evt(CS, 8'h12, 0, 1'b0, 3'b000);
    dec_ok(48'h0123_4567_89ab, 8'h0e);
  endtask
  task automatic t_key_supply;
    slow = 1;
    kreq(48'hc0de_0000_0001);
    send(crkr_pkg::OPC_KEY_SUPPLY, 48'hc0de_0000_0003, 0, 128'h1);
    get_evt(CC, 8'h02, 48'hc0de_0000_0003, 1'b0, 3'b000);
    send(crkr_pkg::OPC_KEY_SUPPLY, 48'hc0de_0000_0001, 0, 128'hfeed_0000_beef_1234);
    get_evt(CC, 8'h00, 48'hc0de_0000_0001, 1'b0, 3'b010);
    chk("key", 128'hfeed_0000_beef_1234, ko);
    slow = 0;
  endtask
  task automatic t_key_absent;
    kreq(48'hd00d_0000_0002);
    send(crkr_pkg::OPC_KEY_ABSENT, 48'hd00d_0000_0006, 0, 0);
    get_evt(CC, 8'h02, 48'hd00d_0000_0006, 1'b0, 3'b000);
    send(crkr_pkg::OPC_KEY_ABSENT, 48'hd00d_0000_0002, 0, 0);
    get_evt(CC, 8'h00, 48'hd00d_0000_0002, 1'b0, 3'b001);
  endtask
  task automatic t_unknown;
    send(10'h00d, 48'h0000_0000_0001, 0, 0);
    get_evt(CS, 8'h01, 0, 1'b0, 3'b000);
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #2 clk = ~clk;
  initial
  begin
    #40000;
    mismatches++;
    print_verdict();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    t_decline();
    t_decline_refused();
    t_key_supply();
    t_key_absent();
    t_unknown();
    print_verdict();
  end
endmodule
